// File: bench/vms_host.sv
// Host model: issues word read and write commands
`timescale 1ns/1ps
`default_nettype none
module vms_host (
  input wire logic ref_clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_invalid,
  input wire logic rsp_unsupported
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One command, answer taken at the second edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q,
                      output logic [2:0] f);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;
    @(posedge ref_clk);
    q = rsp_rdata;
    f = {rsp_valid, rsp_invalid, rsp_unsupported};
  endtask
  // Write directly followed by a read of the same code
  task automatic wr_rd(input logic [7:0] c, input logic [15:0] d, output logic [15:0] q, output logic [2:0] f);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_write <= 1'b0;
    cmd_wdata <= ~d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    f = {rsp_valid, rsp_invalid, rsp_unsupported};
    @(posedge ref_clk);
    q = rsp_rdata;
  endtask
endmodule
`default_nettype wire

// File: bench/vms_regs_bench.sv
// Testbench: command access, slew, loop scale and margin ramp
`timescale 1ns/1ps
`default_nettype none
module vms_regs_bench;
  import vms_pkg::*;
  localparam logic [2:0] OK = 3'h4;
  localparam logic [2:0] INV = 3'h6;
  logic ref_clk, rst, cmd_valid, cmd_write, rsp_valid, rsp_invalid, rsp_unsupported, vout_settled;
  logic conversion_en, onoff_ramp, supply_below_lockout, status_clear, invalid_data_flag, limit_warn_flag;
  logic [7:0] cmd_code;
  logic [1:0] margin_sel;
  logic [15:0] cmd_wdata, rsp_rdata, trim_value, command_value, vout_max_value, vout_min_value, vout_level;
  logic [15:0] scale_applied, q, nvm_margin_low, ctrl_ref_level;
  logic nvm_load, limit_warn_event;
  logic [10:0] nvm_slew_mantissa, nvm_scale_mantissa;
  logic [31:0] slew_applied_q8;
  logic [2:0] f;
  vms_div_type divider_sel;
  int miscompares = 0;
  int compares = 0;
  int n;
  logic [15:0] sw [6] = '{16'hE020, 16'hC012, 16'hE0FE, 16'hC011, 16'hE0FF, 16'hE410};
  logic [15:0] sr [6] = '{16'hE020, 16'hC012, 16'hE0FE, 16'hE0FE, 16'hE0FE, 16'hE0FE};
  logic [31:0] sq [6] = '{32'h00000200, 32'h00000010, 32'h00000FE0, 32'h00000FE0, 32'h00000FE0, 32'h00000FE0};
  logic [2:0] sf [6] = '{OK, OK, OK, INV, INV, INV};
  logic [15:0] lw [4] = '{16'hC880, 16'hC840, 16'hC820, 16'hC810};
  vms_div_type ld [4] = '{DIV_NONE, DIV_1_1, DIV_1_3, DIV_1_7};
  vms_host i_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_invalid(rsp_invalid),
    .rsp_unsupported(rsp_unsupported));
  vms_regs i_dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_invalid(rsp_invalid), .rsp_unsupported(rsp_unsupported), .margin_sel(margin_sel),
    .trim_value(trim_value), .command_value(command_value), .vout_max_value(vout_max_value),
    .vout_min_value(vout_min_value), .conversion_en(conversion_en), .onoff_ramp(onoff_ramp),
    .nvm_load(nvm_load), .nvm_margin_low(nvm_margin_low), .nvm_slew_mantissa(nvm_slew_mantissa),
    .nvm_scale_mantissa(nvm_scale_mantissa),
    .supply_below_lockout(supply_below_lockout), .status_clear(status_clear), .vout_level(vout_level),
    .vout_settled(vout_settled), .ctrl_ref_level(ctrl_ref_level), .divider_sel(divider_sel),
    .scale_applied(scale_applied),
    .slew_applied_q8(slew_applied_q8), .invalid_data_flag(invalid_data_flag),
    .limit_warn_flag(limit_warn_flag), .limit_warn_event(limit_warn_event));
  ////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [2:0] ef);
    i_host.xfer(1'b1, c, d, q, f);
    chk(f, ef);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    i_host.xfer(1'b0, c, 16'h0000, q, f);
    chk(q, e);
  endtask
  task automatic settle();
    n = 0;
    tick(2);
    while (vout_settled !== 1'b1 && n < 8000) begin
      tick(1);
      n++;
    end
    if (n >= 8000) begin
      miscompares++;
      $display("CHECK FAILED %0t settle timeout", $time);
    end
  endtask
  task automatic clear_flags();
    status_clear <= 1'b1;
    tick(1);
    status_clear <= 1'b0;
    tick(1);
  endtask
  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    tick(20000);
    miscompares++;
    results();
  end
  initial begin
    rst <= 1'b1;
    margin_sel <= MARGIN_NONE;
    trim_value <= 16'h0000;
    command_value <= 16'h0200;
    vout_max_value <= 16'h0400;
    vout_min_value <= 16'h0010;
    conversion_en <= 1'b0;
    onoff_ramp <= 1'b0;
    supply_below_lockout <= 1'b0;
    status_clear <= 1'b0;
    nvm_load <= 1'b0;
    nvm_margin_low <= 16'h0000;
    nvm_slew_mantissa <= 11'h000;
    nvm_scale_mantissa <= 11'h000;
    tick(16);
    rst <= 1'b0;
    rd(CMD_MARGIN_LOW, 16'h0000);
    rd(CMD_SLEW_RATE, 16'hE010);
    rd(CMD_LOOP_SCALE, 16'hC880);
    chk(slew_applied_q8, 32'h00000100);
    for (int i = 0; i < 6; i++) begin
      i_host.wr_rd(CMD_SLEW_RATE, sw[i], q, f);
      chk(f, sf[i]);
      chk(q, sr[i]);
      tick(1);
      chk(slew_applied_q8, sq[i]);
    end
    chk(invalid_data_flag, 1'b1);
    clear_flags();
    chk(invalid_data_flag, 1'b0);
    wr(8'h28, 16'h1234, 3'h5);
    for (int i = 0; i < 4; i++) begin
      wr(CMD_LOOP_SCALE, lw[i], OK);
      tick(3);
      chk(divider_sel, ld[i]);
    end
    wr(CMD_LOOP_SCALE, 16'hC900, INV);
    wr(CMD_LOOP_SCALE, 16'h0000, INV);
    conversion_en <= 1'b1;
    tick(3);
    wr(CMD_LOOP_SCALE, 16'hC840, OK);
    rd(CMD_LOOP_SCALE, 16'hC840);
    tick(3);
    chk(scale_applied, 16'hC810);
    supply_below_lockout <= 1'b1;
    tick(1);
    supply_below_lockout <= 1'b0;
    tick(4);
    chk(scale_applied, 16'hC840);
    chk(divider_sel, DIV_1_1);
    wr(CMD_MARGIN_LOW, 16'h0404, INV);
    wr(CMD_MARGIN_LOW, 16'h0100, OK);
    trim_value <= 16'h0008;
    margin_sel <= MARGIN_LOW;
    tick(20);
    chk(vout_level > 16'h01F0, 1'b1);
    settle();
    chk(vout_level, 16'h0108);
    chk(n > 3600 && n < 4000, 1'b1);
    vout_max_value <= 16'h0120;
    margin_sel <= MARGIN_NONE;
    command_value <= 16'h0500;
    tick(2);
    chk(limit_warn_event, 1'b1);
    settle();
    chk(vout_level, 16'h0120);
    chk(limit_warn_flag, 1'b1);
    clear_flags();
    vout_min_value <= 16'h0100;
    command_value <= 16'h0000;
    settle();
    chk(vout_level, 16'h0100);
    chk(limit_warn_flag, 1'b1);
    onoff_ramp <= 1'b1;
    command_value <= 16'h0108;
    tick(4);
    chk(vout_level, 16'h0110);
    onoff_ramp <= 1'b0;
    tick(3);
    chk(ctrl_ref_level, 16'h0088);
    nvm_margin_low <= 16'h0123;
    nvm_slew_mantissa <= 11'h020;
    nvm_scale_mantissa <= 11'h010;
    nvm_load <= 1'b1;
    tick(1);
    nvm_load <= 1'b0;
    tick(2);
    chk(scale_applied, 16'hC810);
    chk(divider_sel, DIV_1_7);
    rd(CMD_MARGIN_LOW, 16'h0123);
    rd(CMD_SLEW_RATE, 16'hE020);
    rd(CMD_LOOP_SCALE, 16'hC810);
    results();
  end
endmodule
`default_nettype wire

// File: bench/vms_regs_monitor.sv
// Checker: command answers, loop scale use, slew steps and output limits
`timescale 1ns/1ps
`default_nettype none
module vms_regs_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_invalid,
  input wire logic conversion_en,
  input wire logic onoff_ramp,
  input wire logic supply_below_lockout,
  input wire logic nvm_load,
  input wire logic [15:0] vout_max_value,
  input wire logic [15:0] vout_min_value,
  input wire logic [15:0] vout_level,
  input wire logic vout_settled,
  input wire vms_pkg::vms_div_type divider_sel,
  input wire logic [15:0] scale_applied,
  input wire logic invalid_data_flag
);
  import vms_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] wdata_ff;
  always_ff @(posedge ref_clk) begin
    if (cmd_valid && cmd_write) begin
      wdata_ff <= cmd_wdata;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_slew_wr;
    cmd_valid && cmd_write && cmd_code == CMD_SLEW_RATE;
  endsequence
  sequence s_slew_rd_ok;
    cmd_valid && !cmd_write && cmd_code == CMD_SLEW_RATE && rsp_valid && !rsp_invalid;
  endsequence
  sequence s_scale_wr_off;
    cmd_valid && cmd_write && cmd_code == CMD_LOOP_SCALE && !conversion_en ##1 rsp_valid && !rsp_invalid;
  endsequence
  sequence s_steady;
    conversion_en [*4] ##0 (vout_settled && $stable(vout_max_value) && $stable(vout_min_value)) [*2];
  endsequence
  property p_rd_back;
    s_slew_wr ##1 s_slew_rd_ok |=> rsp_rdata == wdata_ff;
  endproperty
  property p_inv_slew;
    s_slew_wr ##0 cmd_wdata[MAN_MSB] |=> rsp_valid && rsp_invalid;
  endproperty
  property p_inv_flag;
    rsp_invalid |-> ##[0:1] invalid_data_flag;
  endproperty
  property p_scale_hold;
    conversion_en && $past(conversion_en) && $past(conversion_en, 2) && !$past(supply_below_lockout)
      && !$past(supply_below_lockout, 2) && !$past(rst) && !$past(rst, 2) && !$past(nvm_load)
      |-> $stable(scale_applied);
  endproperty
  property p_scale_off;
    s_scale_wr_off |-> ##[1:2] scale_applied == wdata_ff;
  endproperty
  property p_div;
    (scale_applied == 16'hC840) [*3] |-> divider_sel == DIV_1_1;
  endproperty
  property p_vmax;
    s_steady |-> vout_level <= vout_max_value;
  endproperty
  property p_vmin;
    s_steady |-> vout_level >= vout_min_value;
  endproperty
  property p_slew;
    conversion_en && !onoff_ramp && $past(conversion_en) && !$past(onoff_ramp) && $past(conversion_en, 2)
      && !$past(onoff_ramp, 2) && vout_level != $past(vout_level)
      |-> vout_level == $past(vout_level) + 16'h0001 || vout_level == $past(vout_level) - 16'h0001;
  endproperty
  a_rd_back: assert property (p_rd_back)
    else $error("slew word not read back");
  a_inv_slew: assert property (p_inv_slew)
    else $error("negative slew mantissa accepted");
  a_inv_flag: assert property (p_inv_flag)
    else $error("invalid data flag not set");
  a_scale_hold: assert property (p_scale_hold)
    else $error("loop scale changed while converting");
  a_scale_off: assert property (p_scale_off)
    else $error("loop scale not applied while disabled");
  a_div: assert property (p_div)
    else $error("divider wrong for half scale");
  a_vmax: assert property (p_vmax)
    else $error("level above maximum");
  a_vmin: assert property (p_vmin)
    else $error("level below minimum");
  a_slew: assert property (p_slew)
    else $error("level stepped by more than one code");
endmodule
bind vms_regs vms_regs_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
  .rsp_rdata(rsp_rdata), .rsp_invalid(rsp_invalid), .conversion_en(conversion_en), .onoff_ramp(onoff_ramp),
  .supply_below_lockout(supply_below_lockout), .nvm_load(nvm_load), .vout_max_value(vout_max_value),
  .vout_min_value(vout_min_value), .vout_level(vout_level), .vout_settled(vout_settled),
  .divider_sel(divider_sel), .scale_applied(scale_applied), .invalid_data_flag(invalid_data_flag));
`default_nettype wire

// File: verilog/vms_pkg.sv
// Package: command codes, field layout, reset patterns and timing constants
package vms_pkg;

  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
  localparam logic [7:0] CMD_LOOP_SCALE = 8'h29;

  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam int MAN_W = 11;

  localparam logic [4:0] SLEW_EXP_RST = 5'h1C;
  localparam logic [4:0] SCALE_EXP_RST = 5'h19;

  // Margin field of the operation command
  localparam logic [1:0] MARGIN_NONE = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;

  // Linear values are handled in units of 1/256
  localparam int Q8_SHIFT = 8;
  localparam int Q8_MAX_SHIFT = 20;
  localparam logic [31:0] Q8_BAD = 32'hFFFFFFFF;
  localparam logic [31:0] Q8_ONE = 32'h00000100;
  localparam logic [31:0] RATE_MIN_Q8 = 32'h00000012;
  localparam logic [31:0] RATE_MAX_Q8 = 32'h00000FEE;
  localparam logic [31:0] RATE_ROUND = 32'h00000008;
  localparam int RATE_QUANT_SHIFT = 4;
  localparam logic [31:0] RATE_QUANT_MIN = 32'h00000010;
  localparam logic [31:0] SCALE_DIV_1_7 = 32'h00000020;
  localparam logic [31:0] SCALE_DIV_1_3 = 32'h00000040;
  localparam logic [31:0] SCALE_DIV_1_1 = 32'h00000080;

  typedef enum logic [1:0] {
    DIV_NONE = 2'b00,
    DIV_1_1 = 2'b01,
    DIV_1_3 = 2'b10,
    DIV_1_7 = 2'b11
  } vms_div_type;

  // Output code LSB is 2^-9 V; slew accumulates rate per clock against one LSB
  localparam longint CLK_MHZ = 125;
  localparam longint VOUT_LSB_NV = 1953125;
  localparam longint NV_PER_MV = 1000000;
  localparam longint STEP_ACC_L = (VOUT_LSB_NV * 256 * CLK_MHZ) / NV_PER_MV;
  localparam logic [31:0] STEP_ACC = STEP_ACC_L[31:0];

  // Linear word to 1/256 units; negative or oversized values give Q8_BAD
  function automatic logic [31:0] lin_to_q8(input logic [15:0] w);
    logic signed [4:0] e;
    logic [10:0] m;
    int sh;
    logic [31:0] r;
    e = w[EXP_MSB:EXP_LSB];
    m = w[MAN_MSB:0];
    sh = int'(e) + Q8_SHIFT;
    r = 32'h0;
    if (m[MAN_MSB]) begin
      r = Q8_BAD;
    end else if (sh > Q8_MAX_SHIFT) begin
      r = Q8_BAD;
    end else if (sh >= 0) begin
      r = {21'h0, m} << sh;
    end else begin
      r = {21'h0, m} >> (-sh);
    end
    return r;
  endfunction

endpackage

// File: verilog/vms_ramp_if.sv
// Interface: target and slew settings from the register bank to the ramp engine
`timescale 1ns/1ps
`default_nettype none
interface vms_ramp_if;
  logic [15:0] target;
  logic [31:0] rate_q8;
  logic bypass;
  logic [15:0] level;
  logic settled;
  modport ctl (output target, output rate_q8, output bypass, input level, input settled);
  modport ramp (input target, input rate_q8, input bypass, output level, output settled);
endinterface
`default_nettype wire

// File: verilog/vms_regs.sv
// Margin-low, slew-rate and loop-scale command registers with output target control
//
// Functional notes
// - Margin low selected: target becomes stored margin-low value plus trim.
// - Output changes entering or leaving margin ramp at the programmed slew rate.
// - Margin-low is 16-bit unsigned; power-up contents come from nonvolatile storage.
// - Out-of-range writes to the three commands are invalid data and flagged.
// - Slew rate applies during conversion only; turn-on and turn-off ramps ignore it.
// - Slew exponent in bits 15:11 resets to minus four, 1/16 mV/us step.
// - Valid slew words read back unchanged; hardware applies nearest supported rate.
// - Slew rate valid from about 0.070 to 15.930 mV/us; others invalid.
// - Slew and scale mantissas in bits 10:0, two's complement, loaded from storage.
// - Loop-scale exponent in bits 15:11, two's complement, fixed reset pattern.
// - Scale applies at once when disabled; else only on restore or lockout.
// - Loop scale maps commanded voltage to control input and selects the divider.
// - During conversion, targets above the maximum clamp to it at slew rate and raise warning.
// - During conversion, targets below the minimum clamp to it at slew rate and raise warning.
`timescale 1ns/1ps
`default_nettype none
module vms_regs #(
  parameter logic [15:0] MARGIN_LOW_RST = 16'h0000,
  parameter logic [10:0] SLEW_MAN_RST = 11'h010,
  parameter logic [10:0] SCALE_MAN_RST = 11'h080
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_invalid,
  output logic rsp_unsupported,
  input wire logic [1:0] margin_sel,
  input wire logic [15:0] trim_value,
  input wire logic [15:0] command_value,
  input wire logic [15:0] vout_max_value,
  input wire logic [15:0] vout_min_value,
  input wire logic conversion_en,
  input wire logic onoff_ramp,
  input wire logic nvm_load,
  input wire logic [15:0] nvm_margin_low,
  input wire logic [10:0] nvm_slew_mantissa,
  input wire logic [10:0] nvm_scale_mantissa,
  input wire logic supply_below_lockout,
  input wire logic status_clear,
  output logic [15:0] vout_level,
  output logic vout_settled,
  output logic [15:0] ctrl_ref_level,
  output vms_pkg::vms_div_type divider_sel,
  output logic [15:0] scale_applied,
  output logic [31:0] slew_applied_q8,
  output logic invalid_data_flag,
  output logic limit_warn_flag,
  output logic limit_warn_event
);
  import vms_pkg::*;

  logic [15:0] margin_low_value_ff;
  logic [15:0] slew_word_ff;
  logic [15:0] scale_word_ff;
  logic [15:0] scale_applied_ff;
  vms_div_type divider_sel_ff;
  logic [31:0] slew_applied_ff;
  logic rsp_valid_ff;
  logic [15:0] rsp_rdata_ff;
  logic rsp_invalid_ff;
  logic rsp_unsupported_ff;
  logic invalid_flag_ff;
  logic warn_flag_ff;
  logic warn_event_ff;
  logic [16:0] raw_prev_ff;
  logic [15:0] ctrl_ref_ff;
  logic [16:0] raw_target;
  logic [15:0] base_value;
  logic [15:0] clamped_target;
  logic above_max;
  logic below_min;
  logic wr_ok;
  logic wr_bad;
  logic known_code;
  logic [31:0] wr_q8;
  logic [31:0] scale_q8;
  logic [31:0] slew_q8;
  logic [17:0] margin_sum;
  logic [40:0] ref_prod;

  vms_ramp_if rif ();

  vms_slew u_slew (
    .ref_clk(ref_clk),
    .rst(rst),
    .rif(rif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write checking
  assign wr_q8 = lin_to_q8(cmd_wdata);
  assign margin_sum = {2'b00, cmd_wdata} + {{2{trim_value[15]}}, trim_value};
  assign known_code = (cmd_code == CMD_MARGIN_LOW) || (cmd_code == CMD_SLEW_RATE) ||
                      (cmd_code == CMD_LOOP_SCALE);

  always_comb begin
    wr_ok = 1'b0;
    case (cmd_code)
      CMD_MARGIN_LOW: wr_ok = !margin_sum[17] && (margin_sum[16:0] <= {1'b0, vout_max_value});
      CMD_SLEW_RATE: wr_ok = (wr_q8 >= RATE_MIN_Q8) && (wr_q8 <= RATE_MAX_Q8);
      CMD_LOOP_SCALE: wr_ok = (wr_q8 != 32'h0) && (wr_q8 <= Q8_ONE);
      default: wr_ok = 1'b0;
    endcase
  end

  assign wr_bad = cmd_valid && cmd_write && known_code && !wr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Stored command words
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      margin_low_value_ff <= MARGIN_LOW_RST;
      slew_word_ff <= {SLEW_EXP_RST, SLEW_MAN_RST};
      scale_word_ff <= {SCALE_EXP_RST, SCALE_MAN_RST};
    end else if (nvm_load) begin
      margin_low_value_ff <= nvm_margin_low;
      slew_word_ff <= {slew_word_ff[EXP_MSB:EXP_LSB], nvm_slew_mantissa};
      scale_word_ff <= {scale_word_ff[EXP_MSB:EXP_LSB], nvm_scale_mantissa};
    end else if (cmd_valid && cmd_write && wr_ok) begin
      case (cmd_code)
        CMD_MARGIN_LOW: margin_low_value_ff <= cmd_wdata;
        CMD_SLEW_RATE: slew_word_ff <= cmd_wdata;
        CMD_LOOP_SCALE: scale_word_ff <= cmd_wdata;
        default: margin_low_value_ff <= margin_low_value_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read and write answers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 16'h0000;
      rsp_invalid_ff <= 1'b0;
      rsp_unsupported_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= cmd_valid;
      rsp_invalid_ff <= wr_bad;
      rsp_unsupported_ff <= cmd_valid && !known_code;
      rsp_rdata_ff <= 16'h0000;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          CMD_MARGIN_LOW: rsp_rdata_ff <= margin_low_value_ff;
          CMD_SLEW_RATE: rsp_rdata_ff <= slew_word_ff;
          CMD_LOOP_SCALE: rsp_rdata_ff <= scale_word_ff;
          default: rsp_rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // Sticky invalid-data status; a new error wins over a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      invalid_flag_ff <= 1'b0;
    end else if (wr_bad) begin
      invalid_flag_ff <= 1'b1;
    end else if (status_clear) begin
      invalid_flag_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop scale hardware setting
  assign scale_q8 = lin_to_q8(scale_applied_ff);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scale_applied_ff <= {SCALE_EXP_RST, SCALE_MAN_RST};
    end else if (nvm_load) begin
      scale_applied_ff <= {scale_word_ff[EXP_MSB:EXP_LSB], nvm_scale_mantissa};
    end else if (!conversion_en || supply_below_lockout) begin
      scale_applied_ff <= scale_word_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divider_sel_ff <= DIV_NONE;
    end else if (scale_q8 <= SCALE_DIV_1_7) begin
      divider_sel_ff <= DIV_1_7;
    end else if (scale_q8 <= SCALE_DIV_1_3) begin
      divider_sel_ff <= DIV_1_3;
    end else if (scale_q8 <= SCALE_DIV_1_1) begin
      divider_sel_ff <= DIV_1_1;
    end else begin
      divider_sel_ff <= DIV_NONE;
    end
  end

  // Control input level: output level times the actual scale value
  assign ref_prod = {25'h0, rif.level} * {9'h0, scale_q8};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ref_ff <= 16'h0000;
    end else begin
      ctrl_ref_ff <= ref_prod[23:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied slew rate, rounded to the supported 1/16 mV/us grid
  assign slew_q8 = lin_to_q8(slew_word_ff);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slew_applied_ff <= RATE_QUANT_MIN;
    end else if (((slew_q8 + RATE_ROUND) >> RATE_QUANT_SHIFT) == 32'h0) begin
      slew_applied_ff <= RATE_QUANT_MIN;
    end else begin
      slew_applied_ff <= ((slew_q8 + RATE_ROUND) >> RATE_QUANT_SHIFT) << RATE_QUANT_SHIFT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target selection and limit clamp
  assign base_value = (margin_sel == MARGIN_LOW) ? margin_low_value_ff : command_value;
  assign raw_target = {1'b0, base_value} + {trim_value[15], trim_value};
  assign above_max = !raw_target[16] && (raw_target[15:0] > vout_max_value);
  assign below_min = raw_target[16] || (raw_target[15:0] < vout_min_value);

  always_comb begin
    clamped_target = raw_target[15:0];
    if (conversion_en && above_max) begin
      clamped_target = vout_max_value;
    end else if (conversion_en && below_min) begin
      clamped_target = vout_min_value;
    end else if (raw_target[16]) begin
      clamped_target = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      raw_prev_ff <= 17'h00000;
      warn_event_ff <= 1'b0;
    end else begin
      raw_prev_ff <= raw_target;
      warn_event_ff <= conversion_en && (above_max || below_min) && (raw_target != raw_prev_ff);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warn_flag_ff <= 1'b0;
    end else if (warn_event_ff) begin
      warn_flag_ff <= 1'b1;
    end else if (status_clear) begin
      warn_flag_ff <= 1'b0;
    end
  end

  assign rif.target = clamped_target;
  assign rif.rate_q8 = slew_applied_ff;
  assign rif.bypass = onoff_ramp || !conversion_en;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign rsp_invalid = rsp_invalid_ff;
  assign rsp_unsupported = rsp_unsupported_ff;
  assign vout_level = rif.level;
  assign vout_settled = rif.settled;
  assign ctrl_ref_level = ctrl_ref_ff;
  assign divider_sel = divider_sel_ff;
  assign scale_applied = scale_applied_ff;
  assign slew_applied_q8 = slew_applied_ff;
  assign invalid_data_flag = invalid_flag_ff;
  assign limit_warn_flag = warn_flag_ff;
  assign limit_warn_event = warn_event_ff;
endmodule
`default_nettype wire

// File: verilog/vms_slew.sv
// Ramp engine: moves the output level toward the target at the applied slew rate
`timescale 1ns/1ps
`default_nettype none
module vms_slew (
  input wire logic ref_clk,
  input wire logic rst,
  vms_ramp_if.ramp rif
);
  import vms_pkg::*;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP = 2'b01,
    RAMP_DOWN = 2'b10
  } vms_ramp_type;

  vms_ramp_type state_ff;
  logic [15:0] level_ff;
  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic settled_ff;

  assign nxt_acc = acc_ff + rif.rate_q8;

  ////////////////////////////////////////////////////////////////////////////
  // Direction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= RAMP_IDLE;
    end else if (rif.bypass || level_ff == rif.target) begin
      state_ff <= RAMP_IDLE;
    end else if (level_ff < rif.target) begin
      state_ff <= RAMP_UP;
    end else begin
      state_ff <= RAMP_DOWN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level and rate accumulator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_ff <= 16'h0000;
      acc_ff <= 32'h00000000;
    end else if (rif.bypass) begin
      level_ff <= rif.target;
      acc_ff <= 32'h00000000;
    end else begin
      case (state_ff)
        RAMP_UP: begin
          if (nxt_acc >= STEP_ACC) begin
            acc_ff <= nxt_acc - STEP_ACC;
            if (level_ff < rif.target) begin
              level_ff <= level_ff + 16'h0001;
            end
          end else begin
            acc_ff <= nxt_acc;
          end
        end
        RAMP_DOWN: begin
          if (nxt_acc >= STEP_ACC) begin
            acc_ff <= nxt_acc - STEP_ACC;
            if (level_ff > rif.target) begin
              level_ff <= level_ff - 16'h0001;
            end
          end else begin
            acc_ff <= nxt_acc;
          end
        end
        default: begin
          acc_ff <= 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      settled_ff <= 1'b1;
    end else begin
      settled_ff <= (level_ff == rif.target);
    end
  end

  assign rif.level = level_ff;
  assign rif.settled = settled_ff;
endmodule
`default_nettype wire
